// file: hw/cicr_regs.svh
`ifndef CICR_REGS_SVH
`define CICR_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets on the host control port
// ----------------------------------------------------------------------------
`define CICR_ADDR_W 7
`define CICR_ADDR_IFACE_B 7'h09
`define CICR_ADDR_OFFSET 7'h0A
`define CICR_ADDR_OVF_PLL 7'h0B
`define CICR_ADDR_FILTER 7'h0C

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CICR_RST_IFACE_B 8'h00
`define CICR_RST_OFFSET 8'h00
`define CICR_RST_PLL_R 4'h1
`define CICR_RST_FILTER 8'h00
`define CICR_RST_OVF 4'h0
`define CICR_READ_ZERO 8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CICR_FMT_HI 7
`define CICR_FMT_LO 6
`define CICR_RATE_BIT 3
`define CICR_DAC_RS_BIT 2
`define CICR_ADC_RS_BIT 1
`define CICR_MUTE_BIT 0
`define CICR_OVF_HI 7
`define CICR_OVF_LO 4
`define CICR_PLL_HI 3
`define CICR_PLL_LO 0

// ----------------------------------------------------------------------------
// PLL R decode and word offset limits
// ----------------------------------------------------------------------------
`define CICR_PLL_CODE_MAX 4'h0
`define CICR_PLL_DIV_MAX 5'h10
`define CICR_LIM_CONT 8'h11
`define CICR_LIM_CONT_DSP 8'h10
`define CICR_LIM_256 8'hF2
`define CICR_LIM_256_DSP 8'hF1

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CICR_CLK_NS 40
`define CICR_MUTE_NS 1000
`define CICR_MUTE_CYC ((`CICR_MUTE_NS + `CICR_CLK_NS - 1) / `CICR_CLK_NS)

`endif

// file: hw/cicr_pkg.sv
package cicr_pkg;

  // Serial transfer formats
  typedef enum logic [1:0] {
    CICR_FMT_I2S = 2'h0,
    CICR_FMT_DSP = 2'h1,
    CICR_FMT_RIGHT_ALIGNED = 2'h2,
    CICR_FMT_LEFT_ALIGNED = 2'h3
  } cicr_fmt_e;

  // Realignment sequencer states
  typedef enum logic [2:0] {
    CICR_RS_IDLE = 3'h1,
    CICR_RS_MUTE = 3'h2,
    CICR_RS_ALIGN = 3'h4
  } cicr_rs_state_e;

  // Filter controls, laid out exactly as the filter register
  typedef struct packed {
    logic [1:0] hpf_left;
    logic [1:0] hpf_right;
    logic efx_left;
    logic deemph_left;
    logic efx_right;
    logic deemph_right;
  } cicr_filt_s;

  // One host control port access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } cicr_req_s;

endpackage

// file: hw/cicr_resync.sv
`timescale 1ns/100ps
`include "cicr_regs.svh"

// Realigns one converter to the serial interface when its group delay drifts
module cicr_resync #(
  parameter int W = 16,
  parameter int MUTE_CYC = `CICR_MUTE_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Controls
  input wire logic enable,
  input wire logic mute_sel,
  // Drift measurement
  input wire logic drift_valid,
  input wire logic signed [W-1:0] drift,
  input wire logic [W-1:0] period,
  // Results
  output logic realign,
  output logic soft_mute
);

  // --------------------------------------------------------------------------
  // Drift test
  // --------------------------------------------------------------------------
  // Magnitude of a signed drift; most negative value saturates
  function automatic logic [W-1:0] mag(input logic signed [W-1:0] v);
    logic [W-1:0] r;
    r = v[W-1] ? W'(-v) : W'(v);
    if (v[W-1] && r[W-1]) begin
      r = {1'b0, {(W-1){1'b1}}};
    end
    return r;
  endfunction

  logic exceed; // Drift beyond a quarter sample period either way
  assign exceed = drift_valid && enable && (mag(drift) > (period >> 2));

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  cicr_pkg::cicr_rs_state_e state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next; // Mute ramp time
  logic realign_reg, realign_next;

  // Next state: mute first only when the mute bit asks for it
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    realign_next = 1'b0;
    case (state_reg)
      cicr_pkg::CICR_RS_IDLE: begin
        if (exceed && mute_sel) begin
          state_next = cicr_pkg::CICR_RS_MUTE;
          cnt_next = 16'(MUTE_CYC - 1);
        end else if (exceed) begin
          state_next = cicr_pkg::CICR_RS_ALIGN;
        end
      end
      cicr_pkg::CICR_RS_MUTE: begin
        // Let the soft mute ramp fully before the jump in delay
        if (cnt_reg == 16'h0000) begin
          state_next = cicr_pkg::CICR_RS_ALIGN;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      cicr_pkg::CICR_RS_ALIGN: begin
        realign_next = 1'b1;
        state_next = cicr_pkg::CICR_RS_IDLE;
      end
      default: begin
        state_next = cicr_pkg::CICR_RS_IDLE;
      end
    endcase
  end

  // Registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= cicr_pkg::CICR_RS_IDLE;
      cnt_reg <= 16'h0000;
      realign_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      realign_reg <= realign_next;
    end
  end

  assign realign = realign_reg;
  // With the mute bit set, mute also covers the align state, the cycle before the realign pulse; it is low while realign is high
  assign soft_mute = (state_reg == cicr_pkg::CICR_RS_MUTE) ||
                     (state_reg == cicr_pkg::CICR_RS_ALIGN && mute_sel);

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_unmuted_align;
    @(posedge clk_sys) disable iff (rst)
    (state_reg == cicr_pkg::CICR_RS_IDLE && exceed && !mute_sel) |-> ##2 realign;
  endproperty
  a_unmuted_align:
    assert property (p_unmuted_align) else $error("realign missing after drift");

  property p_muted_before_align;
    @(posedge clk_sys) disable iff (rst)
    $rose(realign) && mute_sel |-> $past(soft_mute);
  endproperty
  a_muted_before_align:
    assert property (p_muted_before_align) else $error("realign without prior mute");

  property p_no_spurious;
    @(posedge clk_sys) disable iff (rst)
    (state_reg == cicr_pkg::CICR_RS_IDLE && !exceed) |=> !realign && !soft_mute;
  endproperty
  a_no_spurious:
    assert property (p_no_spurious) else $error("realign without drift");

endmodule

// file: hw/cicr_top.sv
`timescale 1ns/100ps
`include "cicr_regs.svh"

// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
module cicr_top #(
  parameter int DW = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Host control port
  input wire cicr_pkg::cicr_req_s host_req,
  output logic [7:0] host_rdata,
  // Serial interface timing, sampled on clk_sys
  input wire logic wclk,
  input wire logic bclk,
  output logic data_start,
  output cicr_pkg::cicr_fmt_e serial_fmt,
  output logic bclk_256_mode,
  output logic [7:0] offset_active,
  output logic offset_out_of_range,
  // Overflow events: left ADC, right ADC, left DAC, right DAC
  input wire logic [3:0] ovf_event,
  // PLL and filters
  output logic [4:0] pll_r_div,
  output cicr_pkg::cicr_filt_s filt,
  // Converter drift measurement
  input wire logic adc_drift_valid,
  input wire logic signed [DW-1:0] adc_drift,
  input wire logic [DW-1:0] record_sample_rate,
  input wire logic dac_drift_valid,
  input wire logic signed [DW-1:0] dac_drift,
  input wire logic [DW-1:0] playback_sample_rate,
  // Realignment results
  output logic adc_realign,
  output logic adc_soft_mute,
  output logic dac_realign,
  output logic dac_soft_mute
);

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  logic [7:0] iface_b_reg, iface_b_next;   // serial_iface_ctrl_b
  logic [7:0] offset_reg, offset_next;     // serial_word_offset
  logic [3:0] ovf_reg, ovf_next;           // Sticky flags
  logic [3:0] pll_r_reg, pll_r_next;       // PLL R code
  logic [7:0] filter_reg, filter_next;     // digital_filter_ctrl
  logic [7:0] rdata_reg, rdata_next;       // Read data latch

  // Write strobe for one offset
  function automatic logic wr_hit(input cicr_pkg::cicr_req_s r, input logic [6:0] a);
    return r.wr && (r.addr == a);
  endfunction

  logic ovf_read; // Read of the overflow register
  assign ovf_read = host_req.rd && (host_req.addr == `CICR_ADDR_OVF_PLL);

  // Next register values
  always_comb begin
    iface_b_next = iface_b_reg;
    offset_next = offset_reg;
    pll_r_next = pll_r_reg;
    filter_next = filter_reg;
    if (wr_hit(host_req, `CICR_ADDR_IFACE_B)) begin
      iface_b_next = host_req.wdata;
    end
    if (wr_hit(host_req, `CICR_ADDR_OFFSET)) begin
      offset_next = host_req.wdata;
    end
    if (wr_hit(host_req, `CICR_ADDR_OVF_PLL)) begin
      // Flag bits are read-only; only the divider code is stored
      pll_r_next = host_req.wdata[`CICR_PLL_HI:`CICR_PLL_LO];
    end
    if (wr_hit(host_req, `CICR_ADDR_FILTER)) begin
      filter_next = host_req.wdata;
    end
    // A new overflow in the clearing cycle survives the read
    ovf_next = (ovf_read ? `CICR_RST_OVF : ovf_reg) | ovf_event;
  end

  // Read mux; the flags are captured before the clear lands
  always_comb begin
    rdata_next = rdata_reg;
    if (host_req.rd) begin
      case (host_req.addr)
        `CICR_ADDR_IFACE_B: begin
          rdata_next = iface_b_reg;
        end
        `CICR_ADDR_OFFSET: begin
          rdata_next = offset_reg;
        end
        `CICR_ADDR_OVF_PLL: begin
          rdata_next = {ovf_reg, pll_r_reg};
        end
        `CICR_ADDR_FILTER: begin
          rdata_next = filter_reg;
        end
        default: begin
          rdata_next = `CICR_READ_ZERO; // Unmapped reads as zero
        end
      endcase
    end
  end

  // Register update
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      iface_b_reg <= `CICR_RST_IFACE_B;
      offset_reg <= `CICR_RST_OFFSET;
      ovf_reg <= `CICR_RST_OVF;
      pll_r_reg <= `CICR_RST_PLL_R;
      filter_reg <= `CICR_RST_FILTER;
      rdata_reg <= `CICR_READ_ZERO;
    end else begin
      iface_b_reg <= iface_b_next;
      offset_reg <= offset_next;
      ovf_reg <= ovf_next;
      pll_r_reg <= pll_r_next;
      filter_reg <= filter_next;
      rdata_reg <= rdata_next;
    end
  end

  // --------------------------------------------------------------------------
  // Control decode
  // --------------------------------------------------------------------------
  logic fmt_dsp; // DSP format selected

  assign host_rdata = rdata_reg;
  assign serial_fmt = cicr_pkg::cicr_fmt_e'(iface_b_reg[`CICR_FMT_HI:`CICR_FMT_LO]);
  assign fmt_dsp = (serial_fmt == cicr_pkg::CICR_FMT_DSP);
  assign bclk_256_mode = iface_b_reg[`CICR_RATE_BIT];
  assign filt = cicr_pkg::cicr_filt_s'(filter_reg);
  // Code zero is the largest divider, not a divide by zero
  assign pll_r_div = (pll_r_reg == `CICR_PLL_CODE_MAX) ? `CICR_PLL_DIV_MAX : {1'b0, pll_r_reg};

  // Offset limit for the current mode, flagged but not enforced
  always_comb begin
    logic [7:0] lim;
    lim = `CICR_LIM_CONT;
    if (bclk_256_mode) begin
      lim = fmt_dsp ? `CICR_LIM_256_DSP : `CICR_LIM_256;
    end else begin
      lim = fmt_dsp ? `CICR_LIM_CONT_DSP : `CICR_LIM_CONT;
    end
    offset_out_of_range = (offset_reg > lim);
  end

  // --------------------------------------------------------------------------
  // Frame and bit clock tracking
  // --------------------------------------------------------------------------
  logic wclk_d_reg, wclk_d_next;     // Word clock last cycle
  logic bclk_d_reg, bclk_d_next;     // Bit clock last cycle
  logic [7:0] act_reg, act_next;     // Offset in force this frame
  logic [7:0] bit_cnt_reg, bit_cnt_next;
  logic run_reg, run_next;           // Counting toward data start
  logic start_reg, start_next;
  logic frame_start;
  logic bclk_rise;

  // DSP frames begin on the word clock rise, the others on its fall
  assign frame_start = fmt_dsp ? (wclk && !wclk_d_reg) : (!wclk && wclk_d_reg);
  assign bclk_rise = bclk && !bclk_d_reg;

  // Next tracking state; a frame start outranks a bit clock edge
  always_comb begin
    wclk_d_next = wclk;
    bclk_d_next = bclk;
    act_next = act_reg;
    bit_cnt_next = bit_cnt_reg;
    run_next = run_reg;
    start_next = 1'b0;
    if (frame_start) begin
      // Taking the offset only here keeps every frame consistent
      act_next = offset_reg;
      bit_cnt_next = 8'h00;
      run_next = 1'b1;
    end else if (run_reg && bclk_rise) begin
      if (bit_cnt_reg == act_reg) begin
        start_next = 1'b1;
        run_next = 1'b0;
      end else begin
        bit_cnt_next = bit_cnt_reg + 8'h01;
      end
    end
  end

  // Tracking registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wclk_d_reg <= 1'b0;
      bclk_d_reg <= 1'b0;
      act_reg <= `CICR_RST_OFFSET;
      bit_cnt_reg <= 8'h00;
      run_reg <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      wclk_d_reg <= wclk_d_next;
      bclk_d_reg <= bclk_d_next;
      act_reg <= act_next;
      bit_cnt_reg <= bit_cnt_next;
      run_reg <= run_next;
      start_reg <= start_next;
    end
  end

  assign offset_active = act_reg;
  assign data_start = start_reg;

  // --------------------------------------------------------------------------
  // Converter realignment
  // --------------------------------------------------------------------------
  cicr_resync #(
    .W(DW)
  ) u_adc_resync (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(iface_b_reg[`CICR_ADC_RS_BIT]),
    .mute_sel(iface_b_reg[`CICR_MUTE_BIT]),
    .drift_valid(adc_drift_valid),
    .drift(adc_drift),
    .period(record_sample_rate),
    .realign(adc_realign),
    .soft_mute(adc_soft_mute)
  );

  cicr_resync #(
    .W(DW)
  ) u_dac_resync (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(iface_b_reg[`CICR_DAC_RS_BIT]),
    .mute_sel(iface_b_reg[`CICR_MUTE_BIT]),
    .drift_valid(dac_drift_valid),
    .drift(dac_drift),
    .period(playback_sample_rate),
    .realign(dac_realign),
    .soft_mute(dac_soft_mute)
  );

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_flag_sticky;
    @(posedge clk_sys) disable iff (rst)
    ovf_event[0] ##1 (!ovf_read)[*2] |-> ovf_reg[0];
  endproperty
  a_flag_sticky:
    assert property (p_flag_sticky) else $error("overflow flag lost");

  property p_read_clears;
    @(posedge clk_sys) disable iff (rst)
    (ovf_read && ovf_event == 4'h0) |=> (ovf_reg == 4'h0) && (host_rdata[7:4] == $past(ovf_reg));
  endproperty
  a_read_clears:
    assert property (p_read_clears) else $error("flags not cleared by read");

  property p_pll_decode;
    @(posedge clk_sys) disable iff (rst)
    (pll_r_reg == 4'h0) |-> (pll_r_div == 5'h10);
  endproperty
  a_pll_decode:
    assert property (p_pll_decode) else $error("pll code zero not sixteen");

  property p_offset_frame;
    @(posedge clk_sys) disable iff (rst)
    !$past(frame_start) |-> $stable(offset_active);
  endproperty
  a_offset_frame:
    assert property (p_offset_frame) else $error("offset changed mid frame");

  property p_offset_zero;
    @(posedge clk_sys) disable iff (rst)
    (run_reg && bclk_rise && !frame_start && bit_cnt_reg == act_reg) |=> data_start;
  endproperty
  a_offset_zero:
    assert property (p_offset_zero) else $error("data start missing");

  property p_dsp_edge;
    @(posedge clk_sys) disable iff (rst)
    (fmt_dsp && !wclk_d_reg && wclk) |=> (bit_cnt_reg == 8'h00) && run_reg;
  endproperty
  a_dsp_edge:
    assert property (p_dsp_edge) else $error("dsp frame not on word clock rise");

  property p_filter_map;
    @(posedge clk_sys) disable iff (rst)
    wr_hit(host_req, `CICR_ADDR_FILTER) |=> filt.efx_left == $past(host_req.wdata[3]) &&
      filt.deemph_right == $past(host_req.wdata[0]) && filt.hpf_left == $past(host_req.wdata[7:6]);
  endproperty
  a_filter_map:
    assert property (p_filter_map) else $error("filter bits misplaced");

  property p_limit_256;
    @(posedge clk_sys) disable iff (rst)
    (bclk_256_mode && !fmt_dsp && offset_reg == 8'hF3) |-> offset_out_of_range;
  endproperty
  a_limit_256:
    assert property (p_limit_256) else $error("offset limit not flagged");

endmodule

// file: test/tb_codec_interface_ctrl_regs.sv
`timescale 1ns/100ps
`include "cicr_regs.svh"

module tb_codec_interface_ctrl_regs;
  // --------------------------------------------------------------------------
  // Bench signals
  // --------------------------------------------------------------------------
  logic clk_sys;
  logic rst;
  cicr_pkg::cicr_req_s host_req;
  logic [7:0] host_rdata;
  logic wclk;
  logic bclk;
  logic data_start;
  cicr_pkg::cicr_fmt_e serial_fmt;
  logic bclk_256_mode;
  logic [7:0] offset_active;
  logic offset_out_of_range;
  logic [3:0] ovf_event;
  logic [4:0] pll_r_div;
  cicr_pkg::cicr_filt_s filt;
  logic adc_drift_valid;
  logic signed [15:0] adc_drift;
  logic [15:0] record_sample_rate;
  logic dac_drift_valid;
  logic signed [15:0] dac_drift;
  logic [15:0] playback_sample_rate;
  logic adc_realign;
  logic adc_soft_mute;
  logic dac_realign;
  logic dac_soft_mute;
  int err_count;
  int n_tests;
  // Offset the block should hold after the last frame start we caused
  logic [7:0] exp_act;

  cicr_top #(.DW(16)) DUT (.clk_sys(clk_sys), .rst(rst), .host_req(host_req), .host_rdata(host_rdata),
    .wclk(wclk), .bclk(bclk), .data_start(data_start), .serial_fmt(serial_fmt),
    .bclk_256_mode(bclk_256_mode), .offset_active(offset_active), .offset_out_of_range(offset_out_of_range),
    .ovf_event(ovf_event), .pll_r_div(pll_r_div), .filt(filt), .adc_drift_valid(adc_drift_valid),
    .adc_drift(adc_drift), .record_sample_rate(record_sample_rate), .dac_drift_valid(dac_drift_valid),
    .dac_drift(dac_drift), .playback_sample_rate(playback_sample_rate), .adc_realign(adc_realign),
    .adc_soft_mute(adc_soft_mute), .dac_realign(dac_realign), .dac_soft_mute(dac_soft_mute));

  // --------------------------------------------------------------------------
  // Clock, shared helpers and verdict
  // --------------------------------------------------------------------------
  // 25 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One host access; the request is held across exactly one rising edge
  task automatic bus(input logic w, input logic r, input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    host_req = '{wr: w, rd: r, addr: a, wdata: d};
    @(negedge clk_sys);
    host_req = '0;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask

  // Read data is settled by the falling edge after the taking edge
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    bus(1'b0, 1'b1, a, 8'h00);
    chk(host_rdata, exp);
  endtask

  // Both word clock edges, so a frame starts whatever the format
  task automatic kick();
    @(negedge clk_sys);
    wclk = ~wclk;
    repeat (3) @(negedge clk_sys);
    wclk = ~wclk;
    repeat (3) @(negedge clk_sys);
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  // Reset values, including an unmapped address
  task automatic t_reset();
    rd(`CICR_ADDR_IFACE_B, 8'h00);
    rd(`CICR_ADDR_OFFSET, 8'h00);
    rd(`CICR_ADDR_OVF_PLL, 8'h01);
    rd(`CICR_ADDR_FILTER, 8'h00);
    rd(7'h0D, 8'h00);
    chk(8'(pll_r_div), 8'h01);
    chk(filt, 8'h00);
  endtask

  // Every divider code; the flag bits must not take written ones
  task automatic t_pll();
    for (int c = 0; c < 16; c++) begin
      wr(`CICR_ADDR_OVF_PLL, {4'hF, 4'(c)});
      rd(`CICR_ADDR_OVF_PLL, {4'h0, 4'(c)});
      chk(8'(pll_r_div), (c == 0) ? 8'h10 : 8'(c));
    end
  endtask

  // All highpass codes and enable bits, then a stray write elsewhere
  task automatic t_filter();
    logic [7:0] fv[4] = '{8'h00, 8'h55, 8'hAA, 8'hFF};
    for (int i = 0; i < 4; i++) begin
      wr(`CICR_ADDR_FILTER, fv[i]);
      rd(`CICR_ADDR_FILTER, fv[i]);
      chk(filt, fv[i]);
    end
    wr(7'h0D, 8'h00);
    rd(`CICR_ADDR_FILTER, 8'hFF);
  endtask

  // Format and rate decode with the offset limit of each mode
  task automatic t_mode();
    logic [7:0] cv[5] = '{8'h00, 8'h40, 8'hC0, 8'h88, 8'h48};
    logic [7:0] lv[5] = '{8'h11, 8'h10, 8'h11, 8'hF2, 8'hF1};
    for (int i = 0; i < 5; i++) begin
      wr(`CICR_ADDR_IFACE_B, cv[i]);
      chk(8'(serial_fmt), {6'h00, cv[i][7:6]});
      chk(8'(bclk_256_mode), {7'h00, cv[i][3]});
      for (int k = 0; k < 2; k++) begin
        wr(`CICR_ADDR_OFFSET, lv[i] + 8'(k));
        kick();
        exp_act = lv[i] + 8'(k);
        chk(offset_active, exp_act);
        chk(8'(offset_out_of_range), 8'(k));
      end
    end
    wr(`CICR_ADDR_OFFSET, 8'hFF);
    rd(`CICR_ADDR_OFFSET, 8'hFF);
  endtask

  // Sticky flags, clear on read, and an event landing in the read cycle
  task automatic t_ovf();
    wr(`CICR_ADDR_OVF_PLL, 8'h01);
    for (int b = 0; b < 4; b++) begin
      @(negedge clk_sys);
      ovf_event = 4'h1 << b;
      @(negedge clk_sys);
      ovf_event = 4'h0;
      repeat (3) @(negedge clk_sys);
      rd(`CICR_ADDR_OVF_PLL, {4'h1 << b, 4'h1});
      rd(`CICR_ADDR_OVF_PLL, 8'h01);
    end
    @(negedge clk_sys);
    host_req = '{wr: 1'b0, rd: 1'b1, addr: `CICR_ADDR_OVF_PLL, wdata: 8'h00};
    ovf_event = 4'h8;
    @(negedge clk_sys);
    host_req = '0;
    ovf_event = 4'h0;
    chk(host_rdata, 8'h01);
    rd(`CICR_ADDR_OVF_PLL, 8'h81);
  endtask

  // One frame; bit clock period is four cycles so the latency is unambiguous
  task automatic t_frame(input logic [1:0] fmt, input logic [7:0] off);
    int pulses;
    int at;
    pulses = 0;
    at = 0;
    wr(`CICR_ADDR_IFACE_B, {fmt, 6'h00});
    @(negedge clk_sys);
    wclk = (fmt != 2'h1);
    bclk = 1'b0;
    wr(`CICR_ADDR_OFFSET, off);
    chk(offset_active, exp_act);
    for (int i = 0; i < 4 * int'(off) + 16; i++) begin
      @(negedge clk_sys);
      if (data_start === 1'b1) begin
        pulses++;
        at = i / 4;
      end
      if (i == 0) wclk = ~wclk;
      bclk = (i % 4) >= 2;
    end
    exp_act = off;
    chk(8'(pulses), 8'h01);
    // Bit clock k rises in sample group k-1, so offset N lands in group N
    chk(8'(at), off);
    chk(offset_active, off);
  endtask

  // One drift report on one converter, then watch both channels
  task automatic t_rs(input logic adc, input logic [7:0] ctrl, input logic signed [15:0] d,
                      input logic [7:0] exp_p, input logic exp_m);
    int p;
    int q;
    int mc;
    p = 0;
    q = 0;
    mc = 0;
    wr(`CICR_ADDR_IFACE_B, ctrl);
    @(negedge clk_sys);
    adc_drift = d;
    dac_drift = d;
    adc_drift_valid = adc;
    dac_drift_valid = ~adc;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_sys);
      if ((adc ? adc_realign : dac_realign) === 1'b1) p++;
      if ((adc ? dac_realign : adc_realign) === 1'b1) q++;
      if ((adc ? adc_soft_mute : dac_soft_mute) === 1'b1) mc++;
      if (i == 0) begin
        adc_drift_valid = 1'b0;
        dac_drift_valid = 1'b0;
      end
    end
    chk(8'(p), exp_p);
    chk(8'(q), 8'h00);
    chk(8'(exp_m ? (mc >= 25) : (mc == 0)), 8'h01);
  endtask

  // --------------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------------
  initial begin
    err_count = 0;
    n_tests = 0;
    exp_act = 8'h00;
    rst = 1'b1;
    host_req = '0;
    wclk = 1'b0;
    bclk = 1'b0;
    ovf_event = 4'h0;
    adc_drift_valid = 1'b0;
    adc_drift = 16'sh0000;
    record_sample_rate = 16'h0010;
    dac_drift_valid = 1'b0;
    dac_drift = 16'sh0000;
    playback_sample_rate = 16'h0020;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    t_reset();
    t_pll();
    t_filter();
    t_mode();
    t_ovf();
    t_frame(2'h0, 8'h00);
    t_frame(2'h0, 8'h03);
    t_frame(2'h1, 8'h02);
    t_frame(2'h3, 8'h05);
    t_rs(1'b0, 8'h04, 16'sh0009, 8'h01, 1'b0);
    t_rs(1'b0, 8'h04, 16'sh0008, 8'h00, 1'b0);
    t_rs(1'b0, 8'h04, -16'sh0009, 8'h01, 1'b0);
    t_rs(1'b0, 8'h02, 16'sh0009, 8'h00, 1'b0);
    t_rs(1'b1, 8'h02, 16'sh0005, 8'h01, 1'b0);
    t_rs(1'b1, 8'h02, -16'sh0004, 8'h00, 1'b0);
    t_rs(1'b1, 8'h03, -16'sh0005, 8'h01, 1'b1);
    t_rs(1'b0, 8'h05, 16'sh0009, 8'h01, 1'b1);
    print_verdict();
  end

  // The whole run needs about 700 cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    print_verdict();
  end
endmodule
